/* File: pspm_pkg.sv */
// Constants, commands and states for the pseudo-static RAM host controller
package pspm_pkg;

  // Clock
  localparam int unsigned CLK_NS = 25;

  // Pin timing, in nanoseconds
  localparam int unsigned T_VHMH_NS = 200000;
  localparam int unsigned T_MHCL_NS = 200000;
  localparam int unsigned T_ACC_NS = 65;
  localparam int unsigned T_PAGE_NS = 18;
  localparam int unsigned T_WP_NS = 65;
  localparam int unsigned T_RECOV_NS = 25;

  // Cycle counts: least times round up, none below one
  localparam int unsigned VHMH_CYC = (T_VHMH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned MHCL_CYC = (T_MHCL_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RD_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PG_CYC = (T_PAGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WR_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned GAP_CYC = (T_RECOV_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SYNC_LAT = 2;

  // Device address space and unlock sequence
  localparam logic [21:0] TOP_ADDR = 22'h3fffff;
  localparam logic [21:0] DUMMY_ADDR = 22'h000000;
  localparam logic [15:0] UNLOCK_DATA0 = 16'h0000;
  localparam int unsigned PAGE_BIT = 2;
  localparam logic [1:0] DENS_16M = 2'h0;
  localparam logic [1:0] DENS_8M = 2'h1;
  localparam logic [1:0] DENS_4M = 2'h2;
  localparam logic [1:0] DENS_0M = 2'h3;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_RDATA = 8'h0c;
  localparam logic [7:0] OFS_MODE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // Field positions
  localparam int unsigned CTRL_CMD_LSB = 0;
  localparam int unsigned CTRL_LANE_LSB = 4;

  // Reset values
  localparam logic [1:0] RST_LANES = 2'h3;
  localparam logic [1:0] RST_DENSITY = 2'h0;

  // Commands written to the control register
  localparam logic [2:0] CMD_NONE = 3'h0;
  localparam logic [2:0] CMD_INIT = 3'h1;
  localparam logic [2:0] CMD_READ = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h3;
  localparam logic [2:0] CMD_MODESET = 3'h4;
  localparam logic [2:0] CMD_SLEEP = 3'h5;
  localparam logic [2:0] CMD_WAKE = 3'h6;

  typedef enum logic [2:0] {
    S_PWR_LOW,
    S_PWR_HIGH,
    S_IDLE,
    S_ACC,
    S_GAP,
    S_SB2
  } pspm_state_type;

endpackage : pspm_pkg

/* File: pspm_sync.sv */
// Two-flop synchroniser for the data pins
`timescale 1ns/1ps
module pspm_sync #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } pspm_sync_type;

  pspm_sync_type r;
  pspm_sync_type n;

  always_comb begin
    n = r;
    if (ce_i) begin
      n.s1 = d_i;
      n.s2 = r.s1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign q_o = r.s2;

endmodule : pspm_sync

/* File: pspm_ctrl.sv */
// Host controller driving a pseudo-static RAM, with a Wishbone register port
// Summary of operation
// - Power-up: hold standby pin low, chip select high, then raise standby.
// - After standby rises keep chip select and standby high before accesses.
// - Waking from 0M partial standby repeats the whole power-up sequence.
// - Page is 8 words on the low three address bits; upper bits held.
// - Chip select high or upper address change ends a page.
// - Mode value is undefined at power-up; program it before partial standby.
// - Unlock is two reads then two writes at the top address.
// - First unlock write is 00, second 04 to 07 selects density.
// - Chip select toggles every unlock cycle; output enable toggles in reads.
// - Start unlock only after power-up or an access elsewhere.
//
// Implementation choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module pspm_ctrl #(
  parameter int unsigned INIT_LOW_CYCLES = pspm_pkg::VHMH_CYC,
  parameter int unsigned INIT_HIGH_CYCLES = pspm_pkg::MHCL_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [21:0] mem_addr_o,
  output logic [15:0] mem_dq_o,
  output logic mem_dq_oe_o,
  input wire logic [15:0] mem_dq_i,
  output logic chip_select_n_o,
  output logic output_enable_n_o,
  output logic write_enable_n_o,
  output logic lower_byte_n_o,
  output logic upper_byte_n_o,
  output logic standby_ctrl_o
);

  typedef struct packed {
    pspm_pkg::pspm_state_type st;
    logic [19:0] cnt;
    logic [2:0] ms_idx;
    logic ms_on;
    logic [2:0] pend;
    logic [21:0] addr;
    logic [15:0] wdata;
    logic [1:0] lanes;
    logic [1:0] density;
    logic [15:0] rdata;
    logic init_done;
    logic mode_valid;
    logic page_open;
    logic last_top;
    logic cur_we;
    logic [21:0] a;
    logic [15:0] dq;
    logic dq_oe;
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic lb_n;
    logic ub_n;
    logic sb;
    logic ack;
    logic [31:0] dat;
  } pspm_regs_type;

  pspm_regs_type r;
  pspm_regs_type n;
  logic [15:0] dq_sync;
  logic bus;
  logic go;
  logic [2:0] c;
  logic [2:0] cmd;
  logic cmd_v;
  logic [31:0] m;

  pspm_sync #(
    .WIDTH(16)
  ) u_dq_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(mem_dq_i),
    .q_o(dq_sync)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [31:0] msk);
    merge = (old & ~msk) | (d & msk);
  endfunction : merge

  // Starts one bus cycle on the pins
  function automatic pspm_regs_type launch(input pspm_regs_type s, input logic [21:0] a,
                                           input logic w, input logic [15:0] d,
                                           input logic [1:0] ln, input logic [19:0] len);
    pspm_regs_type t;
    t = s;
    t.a = a;
    t.cs_n = 1'b0;
    t.oe_n = w;
    t.we_n = ~w;
    t.dq_oe = w;
    t.dq = d;
    t.lb_n = ~ln[0];
    t.ub_n = ~ln[1];
    t.cur_we = w;
    t.cnt = len;
    t.st = pspm_pkg::S_ACC;
    t.last_top = (a == pspm_pkg::TOP_ADDR);
    launch = t;
  endfunction : launch

  // One step of the unlock: 0 is the dummy read, 1-2 reads, 3-4 writes
  function automatic pspm_regs_type ms_step(input pspm_regs_type s, input logic [2:0] idx);
    logic [19:0] rd_len;
    logic [19:0] wr_len;
    logic [15:0] last;
    rd_len = 20'(pspm_pkg::RD_CYC + pspm_pkg::SYNC_LAT - 1);
    wr_len = 20'(pspm_pkg::WR_CYC - 1);
    last = 16'h0000;
    last[pspm_pkg::PAGE_BIT] = 1'b1;
    last[1:0] = s.density;
    ms_step = s;
    ms_step.ms_idx = idx;
    case (idx)
      3'h0: ms_step = launch(ms_step, pspm_pkg::DUMMY_ADDR, 1'b0, 16'h0000, 2'h3, rd_len);
      3'h1, 3'h2: ms_step = launch(ms_step, pspm_pkg::TOP_ADDR, 1'b0, 16'h0000, 2'h3, rd_len);
      3'h3: ms_step = launch(ms_step, pspm_pkg::TOP_ADDR, 1'b1, pspm_pkg::UNLOCK_DATA0, 2'h3,
                             wr_len);
      default: ms_step = launch(ms_step, pspm_pkg::TOP_ADDR, 1'b1, last, 2'h3,
                                wr_len);
    endcase
  endfunction : ms_step

  always_comb begin
    n = r;
    go = 1'b0;
    c = pspm_pkg::CMD_NONE;
    m = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    bus = wb_cyc_i && wb_stb_i && !r.ack;
    cmd = wb_dat_i[pspm_pkg::CTRL_CMD_LSB +: 3];
    cmd_v = bus && wb_we_i && (wb_adr_i == pspm_pkg::OFS_CTRL) && wb_sel_i[0];
    n.ack = bus;
    n.dat = 32'h0;
    if (bus && !wb_we_i) begin
      case (wb_adr_i)
        pspm_pkg::OFS_CTRL: n.dat = {26'h0, r.lanes, 4'h0};
        pspm_pkg::OFS_ADDR: n.dat = {10'h0, r.addr};
        pspm_pkg::OFS_WDATA: n.dat = {16'h0, r.wdata};
        pspm_pkg::OFS_RDATA: n.dat = {16'h0, r.rdata};
        pspm_pkg::OFS_MODE: n.dat = {30'h0, r.density};
        pspm_pkg::OFS_STATUS: n.dat = {26'h0, r.last_top, r.page_open, r.mode_valid,
                                       r.st == pspm_pkg::S_SB2, r.init_done,
                                       !(r.st == pspm_pkg::S_IDLE || r.st == pspm_pkg::S_SB2)};
        default: n.dat = 32'h0;
      endcase
    end
    if (bus && wb_we_i) begin
      case (wb_adr_i)
        pspm_pkg::OFS_CTRL: begin
          if (wb_sel_i[0]) begin
            n.lanes = wb_dat_i[pspm_pkg::CTRL_LANE_LSB +: 2];
          end
        end
        pspm_pkg::OFS_ADDR: n.addr = 22'(merge({10'h0, r.addr}, wb_dat_i, m));
        pspm_pkg::OFS_WDATA: n.wdata = 16'(merge({16'h0, r.wdata}, wb_dat_i, m));
        pspm_pkg::OFS_MODE: n.density = 2'(merge({30'h0, r.density}, wb_dat_i, m));
        default: n.density = r.density;
      endcase
    end

    case (r.st)
      pspm_pkg::S_PWR_LOW: begin
        // Chip select already high before the standby pin rises
        n.cs_n = 1'b1;
        n.sb = 1'b0;
        n.page_open = 1'b0;
        if (r.cnt == 20'h0) begin
          n.sb = 1'b1;
          n.cnt = 20'(INIT_HIGH_CYCLES - 1);
          n.st = pspm_pkg::S_PWR_HIGH;
        end else begin
          n.cnt = r.cnt - 20'h1;
        end
      end
      pspm_pkg::S_PWR_HIGH: begin
        if (r.cnt == 20'h0) begin
          n.init_done = 1'b1;
          n.st = pspm_pkg::S_IDLE;
        end else begin
          n.cnt = r.cnt - 20'h1;
        end
      end
      pspm_pkg::S_IDLE: begin
        if (cmd_v && cmd != pspm_pkg::CMD_NONE) begin
          if (r.page_open && !(cmd == pspm_pkg::CMD_READ && n.addr[21:3] == r.a[21:3])) begin
            // Leaving the page: chip select high ends it first
            n.cs_n = 1'b1;
            n.oe_n = 1'b1;
            n.lb_n = 1'b1;
            n.ub_n = 1'b1;
            n.page_open = 1'b0;
            n.pend = cmd;
            n.cnt = 20'(pspm_pkg::GAP_CYC - 1);
            n.st = pspm_pkg::S_GAP;
          end else begin
            go = 1'b1;
            c = cmd;
          end
        end
      end
      pspm_pkg::S_ACC: begin
        if (r.cnt == 20'h0) begin
          if (!r.cur_we) begin
            n.rdata = dq_sync;
          end
          if (!r.cur_we && !r.ms_on) begin
            // Read leaves the page open with chip select low
            n.page_open = 1'b1;
            n.st = pspm_pkg::S_IDLE;
          end else begin
            n.cs_n = 1'b1;
            n.oe_n = 1'b1;
            n.we_n = 1'b1;
            n.dq_oe = 1'b0;
            n.lb_n = 1'b1;
            n.ub_n = 1'b1;
            n.cnt = 20'(pspm_pkg::GAP_CYC - 1);
            n.st = pspm_pkg::S_GAP;
          end
        end else begin
          n.cnt = r.cnt - 20'h1;
        end
      end
      pspm_pkg::S_GAP: begin
        if (r.cnt != 20'h0) begin
          n.cnt = r.cnt - 20'h1;
        end else if (r.ms_on) begin
          if (r.ms_idx == 3'h4) begin
            n.ms_on = 1'b0;
            n.mode_valid = 1'b1;
            n.st = pspm_pkg::S_IDLE;
          end else begin
            n = ms_step(n, r.ms_idx + 3'h1);
          end
        end else if (r.pend != pspm_pkg::CMD_NONE) begin
          go = 1'b1;
          c = r.pend;
          n.pend = pspm_pkg::CMD_NONE;
        end else begin
          n.st = pspm_pkg::S_IDLE;
        end
      end
      pspm_pkg::S_SB2: begin
        n.sb = 1'b0;
        if (cmd_v && (cmd == pspm_pkg::CMD_WAKE || cmd == pspm_pkg::CMD_INIT)) begin
          if (cmd == pspm_pkg::CMD_INIT || r.density == pspm_pkg::DENS_0M || !r.mode_valid) begin
            go = 1'b1;
            c = pspm_pkg::CMD_INIT;
          end else begin
            n.sb = 1'b1;
            n.cnt = 20'(pspm_pkg::GAP_CYC - 1);
            n.st = pspm_pkg::S_GAP;
          end
        end
      end
      default: n.st = pspm_pkg::S_PWR_LOW;
    endcase

    if (go) begin
      case (c)
        pspm_pkg::CMD_INIT: begin
          n.sb = 1'b0;
          n.cs_n = 1'b1;
          n.init_done = 1'b0;
          n.cnt = 20'(INIT_LOW_CYCLES - 1);
          n.st = pspm_pkg::S_PWR_LOW;
        end
        pspm_pkg::CMD_READ: begin
          if (r.page_open) begin
            // Page hit: only the low address bits and lanes move
            n = launch(n, n.addr, 1'b0, 16'h0000, n.lanes,
                       20'(pspm_pkg::PG_CYC + pspm_pkg::SYNC_LAT - 1));
          end else begin
            n = launch(n, n.addr, 1'b0, 16'h0000, n.lanes,
                       20'(pspm_pkg::RD_CYC + pspm_pkg::SYNC_LAT - 1));
          end
        end
        pspm_pkg::CMD_WRITE: begin
          n = launch(n, n.addr, 1'b1, n.wdata, n.lanes, 20'(pspm_pkg::WR_CYC - 1));
        end
        pspm_pkg::CMD_MODESET: begin
          n.ms_on = 1'b1;
          // A dummy read elsewhere first if the last access hit the top address
          n = ms_step(n, r.last_top ? 3'h0 : 3'h1);
        end
        pspm_pkg::CMD_SLEEP: begin
          n.sb = 1'b0;
          n.st = pspm_pkg::S_SB2;
        end
        default: n.st = r.st;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.st <= pspm_pkg::S_PWR_LOW;
      r.cnt <= 20'(INIT_LOW_CYCLES - 1);
      r.lanes <= pspm_pkg::RST_LANES;
      r.density <= pspm_pkg::RST_DENSITY;
      r.cs_n <= 1'b1;
      r.oe_n <= 1'b1;
      r.we_n <= 1'b1;
      r.lb_n <= 1'b1;
      r.ub_n <= 1'b1;
    end else if (ce_i) begin
      r <= n;
    end
  end

  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
  assign mem_addr_o = r.a;
  assign mem_dq_o = r.dq;
  assign mem_dq_oe_o = r.dq_oe;
  assign chip_select_n_o = r.cs_n;
  assign output_enable_n_o = r.oe_n;
  assign write_enable_n_o = r.we_n;
  assign lower_byte_n_o = r.lb_n;
  assign upper_byte_n_o = r.ub_n;
  assign standby_ctrl_o = r.sb;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_SB_RISE_CS_HIGH: assert property ($rose(standby_ctrl_o) |-> chip_select_n_o)
    else $error("standby pin rose with chip select low");

  AST_HOLD_HIGH: assert property (r.st == pspm_pkg::S_PWR_HIGH |->
    chip_select_n_o && standby_ctrl_o && !r.init_done)
    else $error("init hold interval broken");

  AST_READY_FROM_HOLD: assert property ($rose(r.init_done) |->
    $past(r.st) == pspm_pkg::S_PWR_HIGH && $past(r.cnt) == 20'h0)
    else $error("ready without full hold interval");

  AST_PAGE_UPPER_STABLE: assert property (!chip_select_n_o && $past(!chip_select_n_o) |->
    mem_addr_o[21:3] == $past(mem_addr_o[21:3]))
    else $error("upper address moved inside a page");

  AST_MS_TOP_ADDR: assert property (r.ms_on && r.ms_idx != 3'h0 && !chip_select_n_o |->
    mem_addr_o == pspm_pkg::TOP_ADDR)
    else $error("unlock cycle off the top address");

  AST_MS_FIRST_WRITE: assert property (r.ms_on && r.ms_idx == 3'h3 && !chip_select_n_o |->
    !write_enable_n_o && mem_dq_oe_o && mem_dq_o == pspm_pkg::UNLOCK_DATA0)
    else $error("first unlock write not zero");

  AST_MS_LAST_WRITE: assert property (r.ms_on && r.ms_idx == 3'h4 && !chip_select_n_o |->
    !write_enable_n_o && mem_dq_o == {14'h0001, r.density})
    else $error("second unlock write wrong");

  AST_MS_READ_OE: assert property (r.ms_on && r.ms_idx inside {3'h1, 3'h2} &&
    !chip_select_n_o |-> !output_enable_n_o && write_enable_n_o)
    else $error("unlock read without output enable");

  AST_MS_TOGGLE: assert property (r.ms_on && r.st == pspm_pkg::S_GAP |->
    chip_select_n_o && output_enable_n_o)
    else $error("chip select not toggled between unlock cycles");

  AST_NO_TOP_BEFORE_MS: assert property ($fell(chip_select_n_o) && r.ms_on &&
    r.ms_idx == 3'h1 |-> !$past(r.last_top))
    else $error("unlock started right after a top access");

  AST_WAKE_0M: assert property (ce_i && r.st == pspm_pkg::S_SB2 &&
    n.st != pspm_pkg::S_SB2 && r.density == pspm_pkg::DENS_0M |=>
    r.st == pspm_pkg::S_PWR_LOW && !standby_ctrl_o)
    else $error("0M wake skipped initialization");

endmodule : pspm_ctrl

/* File: pspm_psram_model.sv */
// Behavioural pseudo-static RAM: standby modes, page reads, mode register unlock
`timescale 1ns/1ps
module pspm_psram_model #(
  parameter int unsigned LOW_CYC = 4,
  parameter int unsigned HIGH_CYC = 4
) (
  input wire logic clk_i,
  input wire logic [21:0] addr_i,
  input wire logic [15:0] dq_i,
  input wire logic cs_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic lb_n_i,
  input wire logic ub_n_i,
  input wire logic mode_i,
  output logic [15:0] dq_o,
  output int err_o
);
  logic [15:0] mem [int];
  logic [1:0] dens = 2'h0;
  logic dens_ok = 1'b0;
  logic need_init = 1'b1;
  logic cs_q = 1'b1;
  logic mode_q = 1'b0;
  logic rd_c = 1'b0;
  logic wr_c = 1'b0;
  logic top_c = 1'b0;
  logic [15:0] dat_c, w, wv;
  logic [15:0] last = 16'h0;
  logic [21:0] lim;
  int ucnt = 0;
  int lo_cnt = 0;
  int hi_cnt = 0;
  initial err_o = 0;
  function automatic logic [15:0] word(input logic [21:0] a);
    return mem.exists(a) ? mem[a] : (a[15:0] ^ 16'h5a5a);
  endfunction : word
  // Released lanes show the inverse of the last value, never a stale copy
  always @* begin
    w = word(addr_i);
    dq_o[7:0] = (mode_i && !cs_n_i && !oe_n_i && we_n_i && !lb_n_i) ? w[7:0] : ~last[7:0];
    dq_o[15:8] = (mode_i && !cs_n_i && !oe_n_i && we_n_i && !ub_n_i) ? w[15:8] : ~last[15:8];
  end
  always @(posedge clk_i) begin
    if (mode_i && !mode_q && need_init && (!cs_n_i || lo_cnt < LOW_CYC)) err_o++;
    lo_cnt = mode_i ? 0 : lo_cnt + 1;
    hi_cnt = (mode_i && cs_n_i) ? hi_cnt + 1 : 0;
    if (need_init && hi_cnt >= HIGH_CYC) need_init = 1'b0;
    if (need_init && mode_i && !cs_n_i) err_o++;
    if (mode_q && !mode_i) begin
      lim = (dens == 2'h0) ? 22'h0fffff : (dens == 2'h1) ? 22'h07ffff : 22'h03ffff;
      foreach (mem[k]) if (!dens_ok || dens == 2'h3 || k > lim) mem[k] = ~mem[k];
      need_init = need_init || !dens_ok || dens == 2'h3;
    end
    if (cs_q && !cs_n_i) begin
      rd_c = 1'b0;
      wr_c = 1'b0;
      top_c = 1'b1;
    end
    if (mode_i && !cs_n_i && !(lb_n_i && ub_n_i)) begin
      top_c = top_c && (addr_i == 22'h3fffff);
      if (!oe_n_i && we_n_i) begin
        rd_c = 1'b1;
        last = word(addr_i);
      end
      if (!we_n_i) begin
        wr_c = 1'b1;
        dat_c = dq_i;
        wv = word(addr_i);
        if (!lb_n_i) wv[7:0] = dq_i[7:0];
        if (!ub_n_i) wv[15:8] = dq_i[15:8];
        if (!(top_c && ucnt >= 2)) mem[addr_i] = wv;
      end
    end
    if (!cs_q && cs_n_i) begin
      if (rd_c && !oe_n_i) err_o++;
      if (rd_c && top_c) ucnt = (ucnt < 2) ? ucnt + 1 : 9;
      else if (wr_c && top_c && ucnt == 2 && dat_c == 16'h0000) ucnt = 3;
      else if (wr_c && top_c && ucnt == 3 && dat_c[15:3] == 13'h0 && dat_c[2]) begin
        dens = dat_c[1:0];
        dens_ok = 1'b1;
        ucnt = 0;
      end
      else ucnt = 0;
    end
    cs_q = cs_n_i;
    mode_q = mode_i;
  end
endmodule : pspm_psram_model

/* File: pspm_ctrl_tb_top.sv */
// Self-checking bench for the pseudo-static RAM host controller
`timescale 1ns/1ps
module pspm_ctrl_tb_top;
  localparam int unsigned LOWC = 4;
  localparam int unsigned HIGHC = 4;
  logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, dq_oe, cs_n, oe_n, we_n;
  logic lb_n, ub_n, sb;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, t;
  logic [21:0] mem_addr_o, a, lim;
  logic [15:0] mem_dq_o, mem_dq_i;
  logic [15:0] exp_mem [int];
  int n_mismatch = 0;
  int total_checks = 0;

  pspm_ctrl #(.INIT_LOW_CYCLES(LOWC), .INIT_HIGH_CYCLES(HIGHC)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_addr_o(mem_addr_o), .mem_dq_o(mem_dq_o),
    .mem_dq_oe_o(dq_oe), .mem_dq_i(mem_dq_i), .chip_select_n_o(cs_n),
    .output_enable_n_o(oe_n), .write_enable_n_o(we_n), .lower_byte_n_o(lb_n),
    .upper_byte_n_o(ub_n), .standby_ctrl_o(sb));
  pspm_psram_model #(.LOW_CYC(LOWC), .HIGH_CYC(HIGHC)) mdl (
    .clk_i(clk_i), .addr_i(mem_addr_o), .dq_i(mem_dq_o), .cs_n_i(cs_n), .oe_n_i(oe_n),
    .we_n_i(we_n), .lb_n_i(lb_n), .ub_n_i(ub_n), .mode_i(sb), .dq_o(mem_dq_i), .err_o());

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic chk_val(input string what, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk_val

  task automatic chk_err(input string what, input int e, input int g);
    total_checks++;
    if (g != e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0d seen %0d", what, e, g);
    end
  endtask : chk_err

  // One classic cycle; the request is held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hf;
    // Only the watchdog ends a wait that never sees ack
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic cmd(input logic [2:0] c, input logic [1:0] ln);
    wb(1'b1, pspm_pkg::OFS_CTRL, {26'h0, ln, 1'b0, c}, t);
  endtask : cmd

  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      wb(1'b0, pspm_pkg::OFS_STATUS, 32'h0, t);
      n++;
    end while ((t[0] !== 1'b0 || t[1] !== 1'b1) && n < 100);
    chk_val("ready", 32'h2, {30'h0, t[1:0]});
  endtask : wait_ready

  task automatic mem_wr(input logic [21:0] wa, input logic [15:0] wd, input logic [1:0] ln);
    logic [15:0] e;
    wb(1'b1, pspm_pkg::OFS_ADDR, {10'h0, wa}, t);
    wb(1'b1, pspm_pkg::OFS_WDATA, {16'h0, wd}, t);
    cmd(pspm_pkg::CMD_WRITE, ln);
    wait_ready;
    e = exp_mem.exists(wa) ? exp_mem[wa] : 16'h0;
    if (ln[0]) e[7:0] = wd[7:0];
    if (ln[1]) e[15:8] = wd[15:8];
    exp_mem[wa] = e;
  endtask : mem_wr

  task automatic mem_rd(input logic [21:0] ra);
    wb(1'b1, pspm_pkg::OFS_ADDR, {10'h0, ra}, t);
    cmd(pspm_pkg::CMD_READ, 2'h3);
    wait_ready;
    wb(1'b0, pspm_pkg::OFS_RDATA, 32'h0, t);
    chk_val("rdata", {16'h0, exp_mem[ra]}, {16'h0, t[15:0]});
  endtask : mem_rd

  function automatic logic [21:0] lim_of(input logic [1:0] dn);
    return (dn == 2'h0) ? 22'h0fffff : (dn == 2'h1) ? 22'h07ffff : 22'h03ffff;
  endfunction : lim_of

  task close_out;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (30000) @(posedge clk_i);
    n_mismatch++;
    $display("[FAIL] run expected done seen timeout");
    close_out;
  end

  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    void'($urandom(34));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, pspm_pkg::OFS_CTRL, 32'h0, t);
    chk_val("ctrl reset", 32'h30, t);
    wb(1'b0, pspm_pkg::OFS_MODE, 32'h0, t);
    chk_val("mode reset", {30'h0, pspm_pkg::RST_DENSITY}, t);
    wb(1'b1, 8'h18, 32'hffffffff, t);
    wb(1'b0, 8'h18, 32'h0, t);
    chk_val("unmapped", 32'h0, t);
    wait_ready;
    chk_err("init faults", 0, mdl.err_o);
    $display("test init done");
    for (int i = 0; i < 6; i++) begin
      a = 22'($urandom) & 22'h3ffff7;
      mem_wr(a, 16'($urandom), 2'h3);
      mem_wr(a, 16'($urandom), 2'($urandom_range(1, 3)));
      mem_rd(a);
    end
    $display("test single done");
    a = 22'($urandom) & 22'h3ffff0;
    mem_wr(a ^ 22'h8, 16'($urandom), 2'h3);
    for (int i = 0; i < 8; i++) mem_wr(a | 22'(i), 16'($urandom), 2'h3);
    for (int i = 0; i < 8; i++) mem_rd(a | 22'((i * 5 + 3) % 8));
    wb(1'b0, pspm_pkg::OFS_STATUS, 32'h0, t);
    chk_val("page open", 32'h1, {31'h0, t[4]});
    mem_rd(a ^ 22'h8);
    $display("test page done");
    for (int k = 0; k < 4; k++) begin
      lim = lim_of(2'(k));
      mem_wr(lim, 16'($urandom), 2'h3);
      mem_wr(lim + 22'h1, 16'($urandom), 2'h3);
      if (k == 1) mem_wr(pspm_pkg::TOP_ADDR, 16'h1234, 2'h3);
      if (k == 1) mem_rd(pspm_pkg::TOP_ADDR);
      wb(1'b1, pspm_pkg::OFS_MODE, 32'(k), t);
      cmd(pspm_pkg::CMD_MODESET, 2'h3);
      wait_ready;
      wb(1'b0, pspm_pkg::OFS_STATUS, 32'h0, t);
      chk_val("mode valid", 32'h1, {31'h0, t[3]});
      chk_val("density", {29'h0, 1'b1, 2'(k)}, {29'h0, mdl.dens_ok, mdl.dens});
      cmd(pspm_pkg::CMD_SLEEP, 2'h3);
      repeat (4) @(posedge clk_i);
      chk_val("standby pin", 32'h0, {31'h0, sb});
      // Clock enable low freezes the controller while in standby
      ce_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk_val("frozen standby pin", 32'h0, {31'h0, sb});
      chk_val("frozen chip select", 32'h1, {31'h0, cs_n});
      ce_i <= 1'b1;
      foreach (exp_mem[j]) if (k == 3 || j > lim) exp_mem[j] = ~exp_mem[j];
      cmd(pspm_pkg::CMD_WAKE, 2'h3);
      wait_ready;
      chk_err("wake faults", 0, mdl.err_o);
      mem_rd(lim);
      mem_rd(lim + 22'h1);
      $display("test density %0d done", k);
    end
    close_out;
  end
endmodule : pspm_ctrl_tb_top
